// ### src/tl_defs.vh
// Constants for the totalizer and linearizer core.
// Assumes inclusion by the design files; definitions only.
`ifndef TL_DEFS_VH
`define TL_DEFS_VH
`define TL_CLK_HZ 50000000
`define TL_TICK_MS 400
`define TL_TICK_CYCLES ((`TL_CLK_HZ / 1000) * `TL_TICK_MS)
`define TL_TB_SEC 2'h0
`define TL_TB_MIN 2'h1
`define TL_TB_HR 2'h2
`define TL_TICKS_SEC 32'h00000001
`define TL_SEC_PER_MIN 32'h0000003C
`define TL_SEC_PER_HR 32'h00000E10
`define TL_TICKS_PER_SEC_X2 32'h00000005
`define TL_SF_ONE 32'h000003E8
`define TL_TOT_MAX 40'sh00000F423F
`define TL_TOT_MIN -40'sh000001869F
`define TL_TOT_SPAN 40'sh00000F4240
`define TL_FRAC_BITS 16
`define TL_NPTS 10
`define TL_NSEG 9
`endif

// ### src/tl_segment.v
// Linearizer segment evaluation: slope interpolation between two input/display pairs.
// Assumes the caller picks the segment; purely combinational.
`timescale 1ns/100ps
`include "tl_defs.vh"
module tl_segment (
    input wire signed [23:0] inLo,
    input wire signed [23:0] inHi,
    input wire signed [23:0] dspLo,
    input wire signed [23:0] dspHi,
    input wire signed [23:0] reading,
    output wire signed [23:0] display
);
    // =====================================================================
    // Interpolation
    wire signed [24:0] dIn;
    wire signed [24:0] dDsp;
    wire signed [24:0] dX;
    wire signed [49:0] prod;
    wire signed [49:0] quot;
    wire signed [49:0] sum;
    assign dIn = {inHi[23], inHi} - {inLo[23], inLo};
    assign dDsp = {dspHi[23], dspHi} - {dspLo[23], dspLo};
    assign dX = {reading[23], reading} - {inLo[23], inLo};
    assign prod = dX * dDsp;
    // Zero-width segment gives its start display rather than dividing by zero
    assign quot = (dIn == 25'sh0) ? 50'sh0 : prod / dIn; // RULE_11
    assign sum = quot + {{26{dspLo[23]}}, dspLo};
    assign display = sum[23:0];
endmodule // tl_segment

// ### src/tl_totalizer.v
// Totalizer and piecewise-linear linearizer core of a strain gage meter.
// Assumes a synchronous reading from the converter and single-cycle
// request pulses; table and setup values are held steady by the caller.
`timescale 1ns/100ps
`include "tl_defs.vh"
// Behaviour
// RULE_01: Add scaled reading each 400 ms tick.
// RULE_02: Time base select gives 1/60/3600 seconds.
// RULE_03: Programmable scale factor multiplies each increment.
// RULE_04: Independent total decimal point, weights 1..10000.
// RULE_05: Stop accumulating below low cutout.
// RULE_06: Negative cutout: decrement between cutout and zero.
// RULE_07: Roll over and flag overflow at limits; overflow toggles on each rollover, so a second rollover clears it.
// RULE_08: Clear total on remote, panel, serial request.
// RULE_09: Total preserved across power loss.
// RULE_10: Alarms may compare total, at tick granularity.
// RULE_11: Interpolate display between programmed coordinate pairs.
// RULE_12: Up to nine segments supported.
// RULE_13: Scaling points must be strictly monotonic.
// RULE_14: Remote input may re-zero the display.
// RULE_15: Panel/serial re-zero; setup walk clears tare.
// RULE_16: End segments extend past outer points.
module tl_totalizer (
    input wire clock,
    input wire sys_rst,
    input wire clockEnable,
    input wire signed [23:0] reading,
    input wire [1:0] time_base_select,
    input wire [15:0] accumulation_scale_factor,
    input wire [2:0] decimal_point_position,
    input wire [2:0] inputDecimalPosition,
    input wire signed [23:0] low_cutout_level,
    input wire remoteReset,
    input wire panelReset,
    input wire serialReset,
    input wire remoteIsRezero,
    input wire remoteRezero,
    input wire panelRezero,
    input wire serialRezero,
    input wire setupWalk,
    input wire restoreValid,
    input wire signed [39:0] restoreTotal,
    input wire [3:0] segmentCount,
    input wire pointWrite,
    input wire [3:0] pointIndex,
    input wire signed [23:0] input_scaling_point,
    input wire signed [23:0] displayScalingPoint,
    input wire alarm1UseTotal,
    input wire alarm2UseTotal,
    output reg signed [39:0] total,
    output reg overflow,
    output reg updateTick,
    output reg signed [23:0] display,
    output reg signed [23:0] tareOffset,
    output reg signed [39:0] alarm1Value,
    output reg signed [39:0] alarm2Value
);
    // =====================================================================
    // Update tick
    localparam [31:0] TICK_CYCLES = `TL_TICK_CYCLES;
    reg [31:0] tickCount;
    wire tickNow;
    assign tickNow = (tickCount == TICK_CYCLES - 32'h00000001);

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tickCount <= 32'h00000000;
            updateTick <= 1'b0;
        end else if (clockEnable) begin
            tickCount <= tickNow ? 32'h00000000 : tickCount + 32'h00000001; // RULE_01
            updateTick <= tickNow;
        end
    end

    // =====================================================================
    // Scaling point table
    reg signed [23:0] inPt [0:`TL_NPTS-1];
    reg signed [23:0] dspPt [0:`TL_NPTS-1];
    genvar gi;
    generate
        for (gi = 0; gi < `TL_NPTS; gi = gi + 1) begin : gPts
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    inPt[gi] <= 24'sh0;
                    dspPt[gi] <= 24'sh0;
                end else if (clockEnable && pointWrite && pointIndex == gi) begin
                    inPt[gi] <= input_scaling_point;
                    dspPt[gi] <= displayScalingPoint;
                end
            end
        end
    endgenerate

    // =====================================================================
    // Segment selection
    // Table is assumed monotonic; a back-tracking table gives an arbitrary
    // but defined segment, which is the price of a single linear scan.
    reg [3:0] seg;
    reg [3:0] lastSeg;
    reg rising;
    integer k;
    always @* begin
        lastSeg = (segmentCount == 4'h0) ? 4'h1 :
            ((segmentCount > 4'h9) ? 4'h9 : segmentCount); // RULE_12
        rising = (inPt[lastSeg] >= inPt[0]); // RULE_13
        seg = 4'h0;
        for (k = 1; k < `TL_NSEG; k = k + 1) begin
            if (k < lastSeg) begin
                if (rising ? (reading >= inPt[k]) : (reading <= inPt[k])) begin
                    seg = k[3:0];
                end
            end
        end
        // Outer segments simply extrapolate beyond the end points
    end // RULE_16

    wire [3:0] segHi;
    wire signed [23:0] segOut;
    assign segHi = seg + 4'h1;
    tl_segment uSeg (
        .inLo(inPt[seg]),
        .inHi(inPt[segHi]),
        .dspLo(dspPt[seg]),
        .dspHi(dspPt[segHi]),
        .reading(reading),
        .display(segOut)
    );

    // =====================================================================
    // Tare and display
    wire rezeroReq;
    assign rezeroReq = (remoteRezero && remoteIsRezero) || panelRezero || serialRezero;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tareOffset <= 24'sh0;
            display <= 24'sh0;
        end else if (clockEnable) begin
            if (rezeroReq) begin
                tareOffset <= segOut; // RULE_14 RULE_15
            end else if (setupWalk) begin
                tareOffset <= 24'sh0; // RULE_15
            end
            display <= segOut - (rezeroReq ? segOut : tareOffset); // RULE_11
        end
    end

    // =====================================================================
    // Increment arithmetic
    // inc = disp * SF/1000 * weight(totDP) / weight(inDP) / (2.5 * TB)
    // 2.5 per second is done as *2 / 5 to stay in integers.
    function [31:0] pow10;
        input [2:0] p;
        begin
            case (p)
                3'h0: pow10 = 32'h00000001;
                3'h1: pow10 = 32'h0000000A;
                3'h2: pow10 = 32'h00000064;
                3'h3: pow10 = 32'h000003E8;
                default: pow10 = 32'h00002710;
            endcase
        end
    endfunction

    reg [31:0] tbSec;
    always @* begin
        case (time_base_select)
            `TL_TB_SEC: tbSec = `TL_TICKS_SEC; // RULE_02
            `TL_TB_MIN: tbSec = `TL_SEC_PER_MIN;
            `TL_TB_HR: tbSec = `TL_SEC_PER_HR;
            default: tbSec = `TL_TICKS_SEC;
        endcase
    end

    wire signed [23:0] procVal;
    wire signed [79:0] numer;
    wire signed [79:0] denom;
    wire signed [79:0] incFull;
    wire signed [39:0] inc;
    assign procVal = display;
    assign numer = {{56{procVal[23]}}, procVal}
        * $signed({64'h0, accumulation_scale_factor}) // RULE_03
        * $signed({48'h0, pow10(decimal_point_position)}) // RULE_04
        * 80'sh2 * (80'sh1 <<< `TL_FRAC_BITS);
    assign denom = $signed({48'h0, `TL_SF_ONE}) * $signed({48'h0, tbSec})
        * $signed({48'h0, pow10(inputDecimalPosition)}) * $signed({48'h0, `TL_TICKS_PER_SEC_X2});
    assign incFull = numer / denom;
    assign inc = incFull[39:0];

    // =====================================================================
    // Accumulation, cutout, rollover
    reg signed [39:0] frac;
    reg signed [39:0] next_frac;
    reg signed [39:0] next_total;
    reg next_overflow;
    reg accumulate;
    reg signed [39:0] raw;

    always @* begin
        next_frac = frac;
        next_total = total;
        next_overflow = overflow;
        raw = 40'sh0;
        // Below cutout stops; a negative cutout lets negative readings
        // between it and zero count the total down
        accumulate = (procVal >= low_cutout_level); // RULE_05 RULE_06
        if (accumulate) begin
            raw = frac + inc;
            next_total = total + (raw >>> `TL_FRAC_BITS);
            next_frac = raw - ((raw >>> `TL_FRAC_BITS) <<< `TL_FRAC_BITS);
            if (next_total > `TL_TOT_MAX) begin
                next_total = next_total - `TL_TOT_SPAN; // RULE_07
                next_overflow = ~overflow;
            end else if (next_total < `TL_TOT_MIN) begin
                next_total = next_total + `TL_TOT_SPAN;
                next_overflow = ~overflow;
            end
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            total <= 40'sh0;
            frac <= 40'sh0;
            overflow <= 1'b0;
        end else if (clockEnable) begin
            if (remoteReset && !remoteIsRezero || panelReset || serialReset) begin
                total <= 40'sh0; // RULE_08
                frac <= 40'sh0;
                overflow <= 1'b0;
            end else if (restoreValid) begin
                total <= restoreTotal; // RULE_09
                frac <= 40'sh0;
            end else if (tickNow) begin
                total <= next_total; // RULE_01
                frac <= next_frac;
                overflow <= next_overflow; // RULE_07
            end
        end
    end

    // =====================================================================
    // Alarm comparator sources
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alarm1Value <= 40'sh0;
            alarm2Value <= 40'sh0;
        end else if (clockEnable) begin
            alarm1Value <= alarm1UseTotal ? total : {{16{display[23]}}, display}; // RULE_10
            alarm2Value <= alarm2UseTotal ? total : {{16{display[23]}}, display};
        end
    end
endmodule // tl_totalizer

// ### bench/tl_front_end.sv
// Front end model: converter reading and scaling table loader.
// Assumes the bench drives level at the falling edge.
`timescale 1ns/100ps
module tl_front_end (
    input wire clock,
    input wire signed [23:0] level,
    output reg signed [23:0] reading,
    output reg pointWrite,
    output reg [3:0] pointIndex,
    output reg signed [23:0] inPoint,
    output reg signed [23:0] dspPoint
);
    // ==========
    // Reading and table
    integer i;
    initial begin
        reading = 24'sh000000;
        pointWrite = 1'b0;
        pointIndex = 4'h0;
        inPoint = 24'sh000000;
        dspPoint = 24'sh000000;
    end
    always @(negedge clock) begin
        reading <= level;
    end
    // Curved display so each segment has its own slope
    task load_table;
        for (i = 0; i < 10; i = i + 1) begin
            pointWrite = 1'b1;
            pointIndex = i[3:0];
            inPoint = 24'(i * 1000);
            dspPoint = 24'(i * i * 100);
            @(negedge clock);
        end
        pointWrite = 1'b0;
    endtask
endmodule // tl_front_end

// ### bench/tl_totalizer_properties.sv
// Port checker for the totalizer core.
// Assumes binding onto every tl_totalizer instance.
`timescale 1ns/100ps
module tl_totalizer_properties (
    input wire clock,
    input wire sys_rst,
    input wire clockEnable,
    input wire signed [23:0] reading,
    input wire remoteReset,
    input wire panelReset,
    input wire serialReset,
    input wire remoteIsRezero,
    input wire remoteRezero,
    input wire panelRezero,
    input wire serialRezero,
    input wire setupWalk,
    input wire restoreValid,
    input wire signed [39:0] restoreTotal,
    input wire alarm1UseTotal,
    input wire alarm2UseTotal,
    input wire signed [39:0] total,
    input wire overflow,
    input wire updateTick,
    input wire signed [23:0] display,
    input wire signed [23:0] tareOffset,
    input wire signed [39:0] alarm1Value,
    input wire signed [39:0] alarm2Value
);
    // ==========
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire clr = clockEnable && (panelReset || serialReset || (remoteReset && !remoteIsRezero));
    wire rz = clockEnable && (panelRezero || serialRezero || (remoteRezero && remoteIsRezero));
    wire ld = clockEnable && restoreValid;
    sequence steady_s;
        clockEnable && $stable(reading) && !setupWalk;
    endsequence
    clear_total_a: assert property (clr |=> total == 0 && !overflow)
        else $error("total not cleared");
    restore_load_a: assert property (ld && !clr |=> total == $past(restoreTotal))
        else $error("saved total not loaded");
    tick_pulse_a: assert property (updateTick |=> !updateTick)
        else $error("tick pulse too long");
    hold_total_a: assert property (!$past(clr || ld) && !updateTick |-> $stable(total))
        else $error("total moved between ticks");
    rezero_zero_a: assert property (steady_s ##1 (rz and steady_s) ##1 steady_s[*2] |=> display == 0)
        else $error("display not zero after rezero");
    setup_clear_a: assert property (clockEnable && setupWalk && !rz |=> tareOffset == 0)
        else $error("tare not cleared");
    alarm_total_a: assert property ($past(clockEnable && alarm1UseTotal) |-> alarm1Value == $past(total))
        else $error("alarm one not on total");
    alarm_input_a: assert property ($past(clockEnable && !alarm2UseTotal) |-> alarm2Value == $past(display))
        else $error("alarm two not on display");
endmodule // tl_totalizer_properties
bind tl_totalizer tl_totalizer_properties u_tl_totalizer_properties (.*);

// ### bench/tb_top.sv
// Self-checking bench for the totalizer core.
// Assumes the front end model and the bound checker.
`timescale 1ns/100ps
module tb_top;
    // ==========
    // Signals
    typedef struct {logic [3:0] seg; logic signed [23:0] rd; logic signed [23:0] dsp;} tl_row_t;
    tl_row_t rows [7];
    logic clock = 1'b0, sysRst = 1'b1, clockEnable = 1'b1, remoteIsRezero = 1'b0;
    logic remoteReset = 1'b0, panelReset = 1'b0, serialReset = 1'b0, setupWalk = 1'b0;
    logic remoteRezero = 1'b0, panelRezero = 1'b0, serialRezero = 1'b0, restoreValid = 1'b0;
    logic alarm1UseTotal = 1'b1, alarm2UseTotal = 1'b0;
    logic [3:0] segmentCount = 4'h9, pointIndex;
    logic signed [23:0] level = 24'sh000000, reading, inPoint, dspPoint, display, tareOffset;
    logic signed [39:0] restoreTotal = 40'sh000001E240, total, alarm1Value, alarm2Value;
    logic pointWrite, overflow, updateTick;
    int miscompares = 0, testsRun = 0, k;
    initial forever #10 clock = ~clock;
    tl_front_end u_tl_front_end (.clock(clock), .level(level), .reading(reading),
        .pointWrite(pointWrite), .pointIndex(pointIndex), .inPoint(inPoint), .dspPoint(dspPoint));
    tl_totalizer u_tl_totalizer (.clock(clock), .sys_rst(sysRst), .clockEnable(clockEnable),
        .reading(reading), .time_base_select(2'h0), .accumulation_scale_factor(16'h03E8),
        .decimal_point_position(3'h0), .inputDecimalPosition(3'h0),
        .low_cutout_level(24'sh000000), .remoteReset(remoteReset), .panelReset(panelReset),
        .serialReset(serialReset), .remoteIsRezero(remoteIsRezero), .remoteRezero(remoteRezero),
        .panelRezero(panelRezero), .serialRezero(serialRezero), .setupWalk(setupWalk),
        .restoreValid(restoreValid), .restoreTotal(restoreTotal), .segmentCount(segmentCount),
        .pointWrite(pointWrite), .pointIndex(pointIndex), .input_scaling_point(inPoint),
        .displayScalingPoint(dspPoint), .alarm1UseTotal(alarm1UseTotal),
        .alarm2UseTotal(alarm2UseTotal), .total(total), .overflow(overflow),
        .updateTick(updateTick), .display(display), .tareOffset(tareOffset),
        .alarm1Value(alarm1Value), .alarm2Value(alarm2Value));
    // ==========
    // Tasks
    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Run is under a hundred cycles; the tick never fires here
    initial begin
        #1000000;
        miscompares++;
        finish_test;
    end
    // ==========
    // Tests
    initial begin
        rows = '{'{4'h9, 1500, 250}, '{4'h9, 9500, 8950}, '{4'h9, -500, -50},
            '{4'h4, 6000, 3000}, '{4'h0, 2000, 200}, '{4'hC, 8500, 7250}, '{4'h9, 4500, 2050}};
        repeat (8) @(negedge clock);
        sysRst = 1'b0;
        check("total after reset", 0, total);
        u_tl_front_end.load_table();
        for (k = 0; k < 7; k++) begin
            segmentCount = rows[k].seg;
            level = rows[k].rd;
            repeat (3) @(negedge clock);
            check("display", rows[k].dsp, display);
        end
        $display("linearizer test done");
        for (k = 0; k < 3; k++) begin
            pulse(restoreValid);
            check("restored total", restoreTotal, total);
            @(negedge clock);
            check("alarm one", restoreTotal, alarm1Value);
            check("alarm two", 40'sd2050, alarm2Value);
            case (k)
                0: pulse(panelReset);
                1: pulse(serialReset);
                default: pulse(remoteReset);
            endcase
            check("cleared total", 0, total);
            check("overflow", 0, overflow);
        end
        restoreValid = 1'b1;
        pulse(panelReset);
        restoreValid = 1'b0;
        check("clear over restore", 0, total);
        pulse(restoreValid);
        remoteIsRezero = 1'b1;
        clockEnable = 1'b0;
        pulse(panelReset);
        check("frozen total", restoreTotal, total);
        clockEnable = 1'b1;
        pulse(remoteReset);
        check("remote as rezero", restoreTotal, total);
        $display("total test done");
        for (k = 0; k < 3; k++) begin
            case (k)
                0: pulse(remoteRezero);
                1: pulse(panelRezero);
                default: pulse(serialRezero);
            endcase
            repeat (3) @(negedge clock);
            check("tare", 2050, tareOffset);
            check("tared display", 0, display);
            pulse(setupWalk);
            repeat (3) @(negedge clock);
            check("walked tare", 0, tareOffset);
            check("untared display", 2050, display);
        end
        $display("tare test done");
        finish_test;
    end
endmodule // tb_top
